// ===== dv/atx_line_mon.sv
// line-side partner: bit clock, clear-to-send and word capture
module atx_line_mon (
    input wire logic clk_sys,
    input wire logic allow,
    input wire logic tx_zero_level,
    input wire logic tx_one_level,
    output logic tx_bit_clock_x4,
    output logic cts_n,
    output logic [31:0] word,
    output logic [5:0] nbits,
    output int words
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] sh = 32'h0;
    logic [5:0] cnt = 6'h0;
    logic z_q = 1'b0;
    logic o_q = 1'b0;
    int idle = 0;
    assign cts_n = !allow;
    initial
    begin
        word = 32'h0;
        nbits = 6'h0;
        words = 0;
        tx_bit_clock_x4 = 1'b0;
        #3;
        forever #40 tx_bit_clock_x4 = !tx_bit_clock_x4;
    end
    // first bit of a 32-bit word on the line lands in bit 0
    always @(posedge clk_sys)
    begin
        z_q <= tx_zero_level;
        o_q <= tx_one_level;
        idle <= (tx_zero_level || tx_one_level) ? 0 : idle + 1;
        if ((tx_zero_level && !z_q) || (tx_one_level && !o_q))
        begin
            sh <= {tx_one_level, sh[31:1]};
            cnt <= cnt + 6'h1;
        end
        if (idle == 100 && cnt != 6'h0)
        begin
            word <= sh;
            nbits <= cnt;
            words <= words + 1;
            cnt <= 6'h0;
        end
    end
endmodule // atx_line_mon

// ===== dv/atx_top_props.sv
// concurrent checks on the transmitter's host and line pins
module atx_props #(
    parameter int TICK = 8
) (
    input wire clk_sys,
    input wire reset_n,
    input wire cs_n,
    input wire wr_n,
    input wire rd_n,
    input wire cd_sel,
    input wire [7:0] data_out,
    input wire data_oe_n,
    input wire tx_zero_level,
    input wire tx_one_level,
    input wire tx_active_n,
    input wire tx_buffer_ready,
    input wire error_flag_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_NULL_MAX = 3 * TICK;
    localparam int GAP_MIN = 16 * TICK - 4;
    wire lvl = tx_zero_level | tx_one_level;
    logic [9:0] null_cnt;

    // null cycles since the last driven level, saturating
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            null_cnt <= 10'h3ff;
        else if (lvl)
            null_cnt <= 10'h000;
        else if (null_cnt != 10'h3ff)
            null_cnt <= null_cnt + 10'h001;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence status_read_s;
        $fell(data_oe_n) && cd_sel;
    endsequence
    sequence host_write_s;
        $past(!wr_n, 1) && $past(!wr_n, 2) && $past(!cs_n, 2);
    endsequence
    sequence host_read_s;
        $past(!rd_n, 1) && $past(!rd_n, 2) && $past(!cs_n, 2);
    endsequence

    levels_exclusive_a: assert property (!(tx_zero_level && tx_one_level))
        else $error("both line levels high");
    word_gap_a: assert property ($rose(lvl) |-> null_cnt < BIT_NULL_MAX || null_cnt >= GAP_MIN)
        else $error("null run neither bit null nor word gap");
    read_drives_bus_a: assert property ($fell(data_oe_n) |-> host_read_s)
        else $error("data bus driven without a read");
    status_clears_a: assert property (status_read_s |-> !error_flag_out)
        else $error("error flag kept after status read");
    status_bits_a: assert property (status_read_s |-> data_out[0] == $past(tx_buffer_ready, 2)
        && data_out[2] == $past(tx_active_n, 2) && data_out[6:4] == 3'h0)
        else $error("status byte disagrees with pins");
    ready_falls_write_a: assert property ($fell(tx_buffer_ready) |-> host_write_s)
        else $error("ready fell without a write");
    active_falls_write_a: assert property ($fell(tx_active_n) |-> host_write_s)
        else $error("active fell without a write");
    error_halts_a: assert property (error_flag_out |-> ##2 !lvl)
        else $error("line driven while error pending");
endmodule // atx_props

bind atx_top atx_props u_props (.clk_sys, .reset_n, .cs_n, .wr_n, .rd_n, .cd_sel, .data_out,
    .data_oe_n, .tx_zero_level, .tx_one_level, .tx_active_n, .tx_buffer_ready, .error_flag_out);

// ===== dv/atx_top_tb.sv
// self-checking bench for the serial word transmitter
module atx_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic cs_n = 1'b1;
    logic wr_n = 1'b1;
    logic rd_n = 1'b1;
    logic cd_sel = 1'b0;
    logic [7:0] data_in = 8'h00;
    logic feature_select_pin = 1'b0;
    logic chip_init_in = 1'b0;
    logic allow = 1'b1;
    wire [7:0] data_out;
    wire data_oe_n, cts_n, tx_bit_clock_x4, tx_zero_level, tx_one_level;
    wire tx_active_n, tx_buffer_ready, error_flag_out, rx_word_ready;
    logic [31:0] word;
    logic [5:0] nbits;
    logic [7:0] rd_val;
    int words;
    int errors = 0;
    int check_count = 0;

    atx_top DUT (.clk_sys, .reset_n, .cs_n, .wr_n, .rd_n, .cd_sel, .data_in, .data_out,
        .data_oe_n, .cts_n, .feature_select_pin, .chip_init_in, .tx_bit_clock_x4,
        .rx_zero_in(1'b0), .rx_one_in(1'b0), .tx_zero_level, .tx_one_level, .tx_active_n,
        .tx_buffer_ready, .error_flag_out, .rx_word_ready);
    atx_line_mon u_line (.clk_sys, .allow, .tx_zero_level, .tx_one_level, .tx_bit_clock_x4,
        .cts_n, .word, .nbits, .words);

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // one strobe cycle, four clocks low and four high
    task automatic bus(input logic cd, input logic wr, input logic [7:0] d);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        cd_sel <= cd;
        data_in <= d;
        wr_n <= !wr;
        rd_n <= wr;
        repeat (4) @(posedge clk_sys);
        rd_val = data_out;
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        cs_n <= 1'b1;
    endtask

    task automatic send_bytes(input logic [31:0] w);
        for (int i = 0; i < 4; i++)
            bus(1'b0, 1'b1, w[8*i +: 8]);
    endtask

    task automatic wait_ready();
        int n = 0;
        while (tx_buffer_ready !== 1'b1 && n < 2000)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(tx_buffer_ready, 1'b1);
    endtask

    task automatic wait_words(input int target);
        int n = 0;
        while (words < target && n < 3000)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(words, target);
    endtask

    task automatic t_reset();
        chk({tx_buffer_ready, tx_active_n, error_flag_out}, 3'h6);
        bus(1'b1, 1'b0, 8'h00);
        chk(rd_val, 8'h05);
    endtask

    task automatic t_eight_bit();
        logic [31:0] w;
        int base;
        for (int m = 0; m < 2; m++)
        begin
            w = 32'h812345a7 ^ m;
            bus(1'b1, 1'b1, m ? 8'h05 : 8'h25);
            if (m == 0)
                w[31] = ~^w[30:0];
            base = words;
            allow <= 1'b0;
            bus(1'b0, 1'b1, w[7:0]);
            chk({tx_buffer_ready, tx_active_n}, 2'h0);
            repeat (300) @(posedge clk_sys);
            chk(words, base);
            allow <= 1'b1;
            for (int i = 1; i < 4; i++)
            begin
                wait_ready();
                bus(1'b0, 1'b1, w[8*i +: 8]);
            end
            wait_words(base + 1);
            chk({word, nbits, tx_active_n}, {w, 6'h20, 1'b1});
        end
    endtask

    task automatic t_underwrite();
        int base;
        base = words;
        bus(1'b0, 1'b1, 8'h3c);
        wait_words(base + 1);
        chk(error_flag_out, 1'b1);
        bus(1'b0, 1'b1, 8'h55);
        repeat (400) @(posedge clk_sys);
        chk(words, base + 1);
        bus(1'b1, 1'b0, 8'h00);
        chk({rd_val[7], error_flag_out}, 2'h2);
        for (int i = 1; i < 4; i++)
        begin
            wait_ready();
            bus(1'b0, 1'b1, i[7:0]);
        end
        wait_words(base + 2);
        chk(word, 32'h03020155);
    endtask

    task automatic t_buffer();
        logic [31:0] w [4];
        int base;
        feature_select_pin <= 1'b1;
        bus(1'b1, 1'b1, 8'h05);
        allow <= 1'b0;
        base = words;
        for (int k = 0; k < 4; k++)
        begin
            w[k] = 32'h11111111 * (k + 1);
            w[k][31] = ~^w[k][30:0];
            chk(tx_buffer_ready, 1'b1);
            send_bytes(w[k]);
        end
        chk(tx_buffer_ready, 1'b0);
        bus(1'b0, 1'b1, 8'hee);
        allow <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            wait_words(base + k + 1);
            chk(word, w[k]);
        end
        send_bytes(w[1]);
        wait_words(base + 5);
        chk(word, w[1]);
    endtask

    task automatic t_labels();
        logic [31:0] w;
        int base;
        bus(1'b1, 1'b1, 8'h85);
        for (int i = 0; i < 8; i++)
            bus(1'b0, 1'b1, 8'h30 + i[7:0]);
        bus(1'b1, 1'b1, 8'h87);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, 1'b0, 8'h00);
            chk(rd_val, 8'h30 + i[7:0]);
        end
        bus(1'b1, 1'b1, 8'h95);
        for (int m = 0; m < 2; m++)
        begin
            base = words;
            w = m ? 32'h0000a577 : 32'h0000a533;
            w[31] = ~^w[30:0];
            send_bytes(w);
            repeat (1600) @(posedge clk_sys);
            chk(words, base);
            chk(rx_word_ready, m == 0);
            for (int i = 0; i < 4 && m == 0; i++)
            begin
                bus(1'b0, 1'b0, 8'h00);
                chk(rd_val, w[8*i +: 8]);
            end
        end
    endtask

    // init pin flushes the buffer and restores 8-bit mode, self test off
    task automatic t_init();
        int base;
        base = words;
        bus(1'b0, 1'b1, 8'h3c);
        chip_init_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chip_init_in <= 1'b0;
        chk({tx_buffer_ready, error_flag_out}, 2'h2);
        bus(1'b0, 1'b1, 8'h5a);
        wait_words(base + 1);
        chk({nbits, word[31:24], error_flag_out}, {6'h08, 8'h5a, 1'b1});
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        forever #5 clk_sys = !clk_sys;
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_eight_bit();
        t_underwrite();
        t_buffer();
        t_labels();
        t_init();
        complete_run();
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        complete_run();
    end
endmodule // atx_top_tb

// ===== logic/atx_fifo.v
// transmit byte fifo with valid/ready on both sides and a fill count
module atx_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_sys,
    input wire reset_n,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0] count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_reg];
    assign count = count_reg;

    always @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end

    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else if (flush)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push & ~pop)
                count_reg <= count_reg + 1'b1;
            else if (pop & ~push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule // atx_fifo

// ===== logic/atx_sync.v
// two-stage synchroniser for a group of asynchronous pins
module atx_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire clk_sys,
    input wire reset_n,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_reg <= INIT;
            sync_reg <= INIT;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule // atx_sync

// ===== logic/atx_top.v
// serial word transmitter with 8-bit host port, label table and loopback receiver
// Overview of operation
// - select high reaches control/status, low reaches data
// - status read clears all latched error flags
// - control register cannot be read back
// - unmatched labels give no receive indication
// - match enable rising loads next eight writes
// - readback bit rising returns next eight labels
// - self test loops internally, outputs stay null
// - parity enabled puts odd parity in bit 32
// - error output high; transmitter halts until cleared
// - late byte in 8-bit mode sets underwrite
// - word starts only while clear-to-send low
// - enable bit starts transmitter; zero disables it
// - feature select and parity bit choose mode
// - chip init sets control to 8'h25
// - active output low during each word
// - ready high when buffer accepts a byte
// - zero and one levels; both low null
// - status bits: ready 0, idle 2, underwrite 7
// - receiver waits for gap; parity error inhibits operation
// - first byte write drops active, and drops ready in 8-bit mode
`include "atx_map.vh"

module atx_top (
    input wire clk_sys,
    input wire reset_n,
    input wire cs_n,
    input wire wr_n,
    input wire rd_n,
    input wire cd_sel,
    input wire [7:0] data_in,
    output wire [7:0] data_out,
    output wire data_oe_n,
    input wire cts_n,
    input wire feature_select_pin,
    input wire chip_init_in,
    input wire tx_bit_clock_x4,
    input wire rx_zero_in,
    input wire rx_one_in,
    output wire tx_zero_level,
    output wire tx_one_level,
    output wire tx_active_n,
    output wire tx_buffer_ready,
    output wire error_flag_out,
    output wire rx_word_ready
);
    localparam TX_IDLE = 2'b00;
    localparam TX_BIT = 2'b01;
    localparam TX_GAP = 2'b10;

    wire [`ATX_PIN_W-1:0] pins_s;
    wire s_cs_n;
    wire s_wr_n;
    wire s_rd_n;
    wire s_cd;
    wire s_cts_n;
    wire s_hfs;
    wire s_init;
    wire s_txc;
    wire s_rxz;
    wire s_rxo;
    wire [7:0] s_data;

    atx_sync #(.W(`ATX_PIN_W), .INIT(`ATX_PIN_IDLE)) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in({cs_n, wr_n, rd_n, cd_sel, cts_n, feature_select_pin, chip_init_in,
                   tx_bit_clock_x4, rx_zero_in, rx_one_in, data_in}),
        .sync_out(pins_s)
    );
    assign {s_cs_n, s_wr_n, s_rd_n, s_cd, s_cts_n, s_hfs, s_init, s_txc, s_rxz, s_rxo,
            s_data} = pins_s;

    reg wr_prev_reg;
    reg rd_prev_reg;
    reg txc_prev_reg;
    reg drive_reg;
    reg [7:0] rd_data_reg;
    reg [7:0] ctrl_reg;
    reg [3:0] lbl_load_left_reg;
    reg [2:0] lbl_load_idx_reg;
    reg [3:0] lbl_rd_left_reg;
    reg [2:0] lbl_rd_idx_reg;
    reg [7:0] label_mem [0:7];
    reg underwrite_reg;
    reg rx_par_err_reg;
    reg [1:0] tx_state_reg;
    reg [1:0] qtr_reg;
    reg [4:0] bit_idx_reg;
    reg [7:0] byte_reg;
    reg par_acc_reg;
    reg [4:0] gap_cnt_reg;
    reg tx_zero_reg;
    reg tx_one_reg;
    reg rx_prev_reg;
    reg [3:0] rx_null_reg;
    reg rx_armed_reg;
    reg [31:0] rx_shift_reg;
    reg [5:0] rx_cnt_reg;
    reg [31:0] rx_word_reg;
    reg rx_ready_reg;
    reg [1:0] rx_byte_idx_reg;

    wire host_wr = wr_prev_reg & ~s_wr_n & ~s_cs_n;
    wire host_rd = rd_prev_reg & ~s_rd_n & ~s_cs_n;
    wire ctrl_wr = host_wr & s_cd;
    wire data_wr = host_wr & ~s_cd;
    wire stat_rd = host_rd & s_cd;
    wire data_rd = host_rd & ~s_cd;
    wire tick = s_txc & ~txc_prev_reg;
    wire selftest = ctrl_reg[`ATX_CW_SELFTEST];
    wire mode32 = s_hfs & ~ctrl_reg[`ATX_CW_PARITY];
    wire par_en = s_hfs | ctrl_reg[`ATX_CW_PARITY];
    wire err_any = underwrite_reg | rx_par_err_reg;
    wire halt = ~ctrl_reg[`ATX_CW_TX_EN] | err_any;

    wire fifo_in_ready;
    wire fifo_valid;
    wire [7:0] fifo_data;
    wire [`ATX_FIFO_AW:0] fifo_count;
    wire fifo_pop;
    wire fifo_push;
    wire words_avail;
    wire tx_start;
    wire byte_edge;
    wire bitval;
    wire drive_bit;
    wire zero_int;
    wire one_int;

    assign tx_buffer_ready = mode32 ? fifo_in_ready : ~fifo_valid;
    assign fifo_push = data_wr & (lbl_load_left_reg == 4'h0) & tx_buffer_ready;
    assign words_avail = mode32 ? (fifo_count >= `ATX_BYTES_PER_WORD) : fifo_valid;
    assign tx_start = (tx_state_reg == TX_IDLE) & ~halt & ~s_cts_n & words_avail;
    assign byte_edge = (tx_state_reg == TX_BIT) & tick & (qtr_reg == `ATX_QTR_LAST)
                       & (bit_idx_reg[2:0] == 3'h7) & (bit_idx_reg != `ATX_WORD_LAST) & ~halt;
    assign fifo_pop = tx_start | (byte_edge & fifo_valid);

    atx_fifo #(.WIDTH(`ATX_FIFO_WIDTH), .DEPTH(`ATX_FIFO_DEPTH), .AW(`ATX_FIFO_AW)) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .flush(s_init),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(s_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data),
        .count(fifo_count)
    );

    // last bit carries parity or plain data
    assign bitval = (bit_idx_reg == `ATX_WORD_LAST) ?
                    (par_en ? ~par_acc_reg : byte_reg[7]) : byte_reg[bit_idx_reg[2:0]];
    assign drive_bit = (tx_state_reg == TX_BIT) & ~qtr_reg[1];
    assign zero_int = drive_bit & ~bitval;
    assign one_int = drive_bit & bitval;
    assign tx_zero_level = tx_zero_reg;
    assign tx_one_level = tx_one_reg;
    assign tx_active_n = ~((tx_state_reg == TX_BIT) | fifo_valid);
    assign error_flag_out = err_any;
    assign data_out = rd_data_reg;
    assign data_oe_n = ~drive_reg;
    assign rx_word_ready = rx_ready_reg;

    wire [7:0] status_word;
    assign status_word = {underwrite_reg, 3'h0, rx_par_err_reg, tx_active_n,
                          rx_ready_reg, tx_buffer_ready};

    // receiver inputs, looped from the transmitter in self test
    wire rx_z = selftest ? zero_int : s_rxz;
    wire rx_o = selftest ? one_int : s_rxo;
    wire rx_lvl = rx_z | rx_o;
    wire rx_gap_hit = tick & ~rx_lvl & (rx_null_reg == `ATX_RX_GAP_QTRS - 4'h1);
    wire [7:0] lbl_hit;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_match
            assign lbl_hit[g] = (label_mem[g] == rx_shift_reg[7:0]);
        end
    endgenerate
    wire lmatch_on = s_hfs & ctrl_reg[`ATX_CW_LMATCH];
    wire rx_match = ~lmatch_on | (|lbl_hit);
    wire rx_done = rx_gap_hit & (rx_cnt_reg == `ATX_RX_BITS) & rx_match;

    // host port: strobes, control write, label table, reads
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_prev_reg <= 1'b1;
            rd_prev_reg <= 1'b1;
            txc_prev_reg <= 1'b0;
            drive_reg <= 1'b0;
            rd_data_reg <= 8'h00;
            ctrl_reg <= `ATX_CW_RESET;
            lbl_load_left_reg <= 4'h0;
            lbl_load_idx_reg <= 3'h0;
            lbl_rd_left_reg <= 4'h0;
            lbl_rd_idx_reg <= 3'h0;
        end
        else
        begin
            wr_prev_reg <= s_wr_n;
            rd_prev_reg <= s_rd_n;
            txc_prev_reg <= s_txc;
            drive_reg <= ~s_cs_n & ~s_rd_n & ~rd_prev_reg | drive_reg & ~s_cs_n & ~s_rd_n;
            if (s_init)
            begin
                ctrl_reg <= `ATX_CW_RESET;
                lbl_load_left_reg <= 4'h0;
                lbl_rd_left_reg <= 4'h0;
            end
            else
            begin
                if (ctrl_wr)
                begin
                    ctrl_reg <= s_data;
                    if (s_hfs & ~ctrl_reg[`ATX_CW_LMATCH] & s_data[`ATX_CW_LMATCH])
                    begin
                        lbl_load_left_reg <= `ATX_LABEL_SLOTS;
                        lbl_load_idx_reg <= 3'h0;
                    end
                    if (s_hfs & ~ctrl_reg[`ATX_CW_READBACK] & s_data[`ATX_CW_READBACK])
                    begin
                        lbl_rd_left_reg <= `ATX_LABEL_SLOTS;
                        lbl_rd_idx_reg <= 3'h0;
                    end
                end
                else if (data_wr & (lbl_load_left_reg != 4'h0))
                begin
                    lbl_load_left_reg <= lbl_load_left_reg - 4'h1;
                    lbl_load_idx_reg <= lbl_load_idx_reg + 3'h1;
                end
                if (stat_rd)
                    rd_data_reg <= status_word;
                else if (data_rd & (lbl_rd_left_reg != 4'h0))
                begin
                    rd_data_reg <= label_mem[lbl_rd_idx_reg];
                    lbl_rd_left_reg <= lbl_rd_left_reg - 4'h1;
                    lbl_rd_idx_reg <= lbl_rd_idx_reg + 3'h1;
                end
                else if (data_rd)
                    rd_data_reg <= rx_word_reg[{rx_byte_idx_reg, 3'h0} +: 8];
            end
        end
    end

    always @(posedge clk_sys)
    begin
        if (data_wr & (lbl_load_left_reg != 4'h0) & ~s_init)
            label_mem[lbl_load_idx_reg] <= s_data;
    end

    // error flags: a new event beats the clearing read
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            underwrite_reg <= 1'b0;
            rx_par_err_reg <= 1'b0;
        end
        else if (s_init)
        begin
            underwrite_reg <= 1'b0;
            rx_par_err_reg <= 1'b0;
        end
        else
        begin
            if (byte_edge & ~fifo_valid & ~mode32)
                underwrite_reg <= 1'b1;
            else if (stat_rd)
                underwrite_reg <= 1'b0;
            if (rx_done & par_en & ~(^rx_shift_reg))
                rx_par_err_reg <= 1'b1;
            else if (stat_rd)
                rx_par_err_reg <= 1'b0;
        end
    end

    // transmit sequencer, four quarter ticks per bit
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_state_reg <= TX_IDLE;
            qtr_reg <= 2'h0;
            bit_idx_reg <= 5'h00;
            byte_reg <= 8'h00;
            par_acc_reg <= 1'b0;
            gap_cnt_reg <= 5'h00;
            tx_zero_reg <= 1'b0;
            tx_one_reg <= 1'b0;
        end
        else if (s_init)
        begin
            tx_state_reg <= TX_IDLE;
            tx_zero_reg <= 1'b0;
            tx_one_reg <= 1'b0;
        end
        else
        begin
            tx_zero_reg <= zero_int & ~selftest;
            tx_one_reg <= one_int & ~selftest;
            case (tx_state_reg)
                TX_IDLE:
                begin
                    if (tx_start)
                    begin
                        tx_state_reg <= TX_BIT;
                        byte_reg <= fifo_data;
                        bit_idx_reg <= 5'h00;
                        qtr_reg <= 2'h0;
                        par_acc_reg <= 1'b0;
                    end
                end
                TX_BIT:
                begin
                    if (halt)
                    begin
                        tx_state_reg <= TX_GAP;
                        gap_cnt_reg <= 5'h00;
                    end
                    else if (tick)
                    begin
                        qtr_reg <= qtr_reg + 2'h1;
                        if (qtr_reg == `ATX_QTR_LAST)
                        begin
                            par_acc_reg <= par_acc_reg ^ bitval;
                            bit_idx_reg <= bit_idx_reg + 5'h01;
                            if (bit_idx_reg == `ATX_WORD_LAST)
                            begin
                                tx_state_reg <= TX_GAP;
                                gap_cnt_reg <= 5'h00;
                            end
                            else if (byte_edge & fifo_valid)
                                byte_reg <= fifo_data;
                            else if (byte_edge)
                            begin
                                tx_state_reg <= TX_GAP;
                                gap_cnt_reg <= 5'h00;
                            end
                        end
                    end
                end
                TX_GAP:
                begin
                    if (tick)
                    begin
                        gap_cnt_reg <= gap_cnt_reg + 5'h01;
                        if (gap_cnt_reg == `ATX_GAP_QTRS_LAST)
                            tx_state_reg <= TX_IDLE;
                    end
                end
                default:
                    tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // receiver: gap detection, bit capture, label filter
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_prev_reg <= 1'b0;
            rx_null_reg <= 4'h0;
            rx_armed_reg <= 1'b0;
            rx_shift_reg <= 32'h0000_0000;
            rx_cnt_reg <= 6'h00;
            rx_word_reg <= 32'h0000_0000;
            rx_ready_reg <= 1'b0;
            rx_byte_idx_reg <= 2'h0;
        end
        else if (s_init)
        begin
            rx_armed_reg <= 1'b0;
            rx_null_reg <= 4'h0;
            rx_cnt_reg <= 6'h00;
            rx_ready_reg <= 1'b0;
            rx_byte_idx_reg <= 2'h0;
        end
        else
        begin
            rx_prev_reg <= rx_lvl;
            if (rx_lvl)
                rx_null_reg <= 4'h0;
            else if (tick & (rx_null_reg != `ATX_RX_GAP_QTRS))
                rx_null_reg <= rx_null_reg + 4'h1;
            if (rx_gap_hit)
            begin
                rx_armed_reg <= 1'b1;
                rx_cnt_reg <= 6'h00;
            end
            else if (rx_lvl & ~rx_prev_reg & rx_armed_reg & ctrl_reg[`ATX_CW_RX_EN]
                     & ~rx_par_err_reg & (rx_cnt_reg != `ATX_RX_BITS))
            begin
                rx_shift_reg <= {rx_o, rx_shift_reg[31:1]};
                rx_cnt_reg <= rx_cnt_reg + 6'h01;
            end
            if (rx_done)
            begin
                rx_word_reg <= rx_shift_reg;
                rx_ready_reg <= 1'b1;
                rx_byte_idx_reg <= 2'h0;
            end
            else if (data_rd & (lbl_rd_left_reg == 4'h0))
            begin
                rx_byte_idx_reg <= rx_byte_idx_reg + 2'h1;
                if (rx_byte_idx_reg == 2'h3)
                    rx_ready_reg <= 1'b0;
            end
        end
    end
endmodule // atx_top

// ===== shared/atx_map.vh
// register bits, reset values and timing counts of the serial transmitter
`ifndef ATX_MAP_VH
`define ATX_MAP_VH

`define ATX_CW_TX_EN 0
`define ATX_CW_READBACK 1
`define ATX_CW_RX_EN 2
`define ATX_CW_SELFTEST 4
`define ATX_CW_PARITY 5
`define ATX_CW_LMATCH 7
`define ATX_CW_RESET 8'h25

`define ATX_SW_TX_READY 0
`define ATX_SW_RX_READY 1
`define ATX_SW_TX_IDLE 2
`define ATX_SW_RX_PARITY 3
`define ATX_SW_UNDERWRITE 7

`define ATX_WORD_LAST 5'h1f
`define ATX_BYTES_PER_WORD 5'h04
`define ATX_RX_BITS 6'h20
`define ATX_LABEL_SLOTS 4'h8
`define ATX_QTR_LAST 2'h3
`define ATX_GAP_QTRS_LAST 5'h0f
`define ATX_RX_GAP_QTRS 4'hc

`define ATX_FIFO_WIDTH 8
`define ATX_FIFO_DEPTH 16
`define ATX_FIFO_AW 4

`define ATX_PIN_W 18
`define ATX_PIN_IDLE 18'h3a000

`endif
